// ---- rtl/blmx_exec.sv ----
// Functional notes
// (RULE_01) Bit set forces chosen bit of file register to one; flags untouched.
// (RULE_02) AND immediate: accumulator AND literal into accumulator; zero flag only.
// (RULE_03) AND register: result to accumulator (dest 0) or register (dest 1); zero flag.
// (RULE_04) Skip-if-one: bit one discards next instruction as no-op; no flags.
// (RULE_05) Skip-if-zero: bit zero discards next instruction as no-op; no flags.
// (RULE_06) Copy register to accumulator (dest 0) or itself (dest 1); zero flag.
// (RULE_07) Copy back to same register still updates zero flag from value.
// (RULE_08) Zero flag set when result is zero, else cleared; no-op changes nothing.
`timescale 1ns/10ps
`default_nettype none
module blmx_exec
    import blmx_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int DEPTH  = 128
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Instruction issue from decode
    input  wire logic                  instr_valid,
    input  wire blmx_pkg::blmx_instr_t instr,
    // Architectural state out
    output logic [7:0]                 acc_out,
    output logic                       zero_flag,
    output logic                       busy,
    output logic                       skip_taken,
    output logic                       done
);
    import blmx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    blmx_state_t state_r, state_nxt;
    blmx_instr_t held_r;
    logic [7:0]  acc_r, acc_nxt;
    logic        zero_r, zero_nxt;
    logic        skip_r, skip_nxt;
    logic        done_r, done_nxt;
    logic        busy_r;
    logic [7:0]  rf_rd_data;
    logic        rf_wr_en;
    logic [7:0]  rf_wr_data;

    // Ops that load the zero flag from their result
    function automatic logic writes_zero(input blmx_op_t op);
        case (op)
            BLMX_OP_AND_IMM,
            BLMX_OP_AND_REG,
            BLMX_OP_COPY_REG: writes_zero = 1'b1;
            default:          writes_zero = 1'b0;
        endcase
    endfunction

    // Ops whose result lands in the accumulator
    function automatic logic loads_acc(input blmx_op_t op, input logic dest);
        case (op)
            BLMX_OP_AND_IMM:  loads_acc = 1'b1;
            BLMX_OP_AND_REG,
            BLMX_OP_COPY_REG: loads_acc = (dest == BLMX_DEST_ACC);
            default:          loads_acc = 1'b0;
        endcase
    endfunction

    // Ops that write the file register; copy onto itself included
    function automatic logic writes_file(input blmx_op_t op, input logic dest);
        case (op)
            BLMX_OP_SET_BIT:  writes_file = 1'b1;
            BLMX_OP_AND_REG,
            BLMX_OP_COPY_REG: writes_file = (dest == BLMX_DEST_REG);
            default:          writes_file = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file: read launched on issue, data valid in EXEC
    blmx_regfile #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W),
        .DEPTH  (DEPTH)
    ) u_rf (
        .core_clk (core_clk),
        .rd_addr  (instr.addr),
        .rd_data  (rf_rd_data),
        .wr_en    (rf_wr_en),
        .wr_addr  (held_r.addr),
        .wr_data  (rf_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Datapath
    wire        in_exec   = (state_r == BLMX_ST_EXEC);
    // Strobe only counts in idle; a late one while busy is dropped
    wire        take      = (state_r == BLMX_ST_IDLE) & instr_valid;
    logic [7:0] set_val;
    logic [7:0] hit_bits;
    wire        tst_bit   = |hit_bits;

    // One slice per bit: the chosen bit is forced high, others pass
    for (genvar b = 0; b < BLMX_DATA_W; b++) begin : g_bit
        localparam logic [2:0] IDX = 3'(b);
        wire sel = (held_r.bit_sel == IDX);
        assign set_val[b]  = rf_rd_data[b] | sel;                  // [RULE_01]
        assign hit_bits[b] = rf_rd_data[b] & sel;                  // [RULE_04] [RULE_05]
    end

    wire [7:0]  and_imm   = acc_r & held_r.imm;                       // [RULE_02]
    wire [7:0]  and_reg   = acc_r & rf_rd_data;                       // [RULE_03]
    wire        is_set    = (held_r.op == BLMX_OP_SET_BIT);
    wire        is_andi   = (held_r.op == BLMX_OP_AND_IMM);
    wire        is_andr   = (held_r.op == BLMX_OP_AND_REG);
    wire        is_skp1   = (held_r.op == BLMX_OP_SKIP_ONE);
    wire        is_skp0   = (held_r.op == BLMX_OP_SKIP_ZER);
    wire [7:0]  zres      = is_andi ? and_imm : (is_andr ? and_reg : rf_rd_data);
    wire        zupd      = writes_zero(held_r.op);                   // [RULE_08]
    wire        acc_ld    = loads_acc(held_r.op, held_r.dest);        // [RULE_06]
    wire        skip_hit  = (is_skp1 & tst_bit) | (is_skp0 & ~tst_bit); // [RULE_04] [RULE_05]

    // Copy back writes the same value; zero flag still follows it.
    // Cost is one needless write, traded for a simpler enable.
    assign rf_wr_en   = in_exec & writes_file(held_r.op, held_r.dest); // [RULE_07]
    assign rf_wr_data = is_set ? set_val : (is_andr ? and_reg : rf_rd_data);   // [RULE_03]

    always_comb begin
        acc_nxt   = acc_r;
        zero_nxt  = zero_r;
        skip_nxt  = skip_r;
        done_nxt  = 1'b0;
        state_nxt = state_r;
        case (state_r)
            BLMX_ST_IDLE: begin
                if (take) begin
                    state_nxt = BLMX_ST_EXEC;
                end
            end
            BLMX_ST_EXEC: begin
                done_nxt = 1'b1;
                if (zupd) begin
                    zero_nxt = (zres == BLMX_ZERO_VAL);             // [RULE_08]
                end
                if (acc_ld) begin
                    acc_nxt = zres;                                  // [RULE_02] [RULE_06]
                end
                skip_nxt  = skip_hit;
                state_nxt = skip_hit ? BLMX_ST_FLUSH : BLMX_ST_IDLE;
            end
            BLMX_ST_FLUSH: begin
                // Discarded slot executes as a no-op cycle
                skip_nxt  = 1'b0;
                state_nxt = BLMX_ST_IDLE;                            // [RULE_04] [RULE_05]
            end
            default: begin
                state_nxt = BLMX_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= BLMX_ST_IDLE;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Busy follows the next state so the port comes from a flop
            busy_r  <= (state_nxt != BLMX_ST_IDLE);
        end
    end

    // Instruction capture; the issuer may change instr right after
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            held_r <= '0;
        end else if (take) begin
            held_r <= instr;
        end
    end

    // Accumulator and zero flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_r  <= BLMX_ACC_RST;
            zero_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            zero_r <= zero_nxt;
        end
    end

    // One-cycle status pulses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            skip_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            skip_r <= skip_nxt;
            done_r <= done_nxt;
        end
    end

    assign acc_out    = acc_r;
    assign zero_flag  = zero_r;
    assign skip_taken = skip_r;
    assign done       = done_r;
    assign busy       = busy_r;
endmodule
`default_nettype wire

// ---- rtl/blmx_pkg.sv ----
package blmx_pkg;

    localparam int BLMX_DATA_W = 8;
    localparam int BLMX_ADDR_W = 7;
    localparam int BLMX_BIT_W  = 3;
    localparam int BLMX_DEPTH  = 128;

    localparam logic [7:0] BLMX_ACC_RST  = 8'h00;
    localparam logic [7:0] BLMX_ZERO_VAL = 8'h00;

    // Destination select encoding
    localparam logic BLMX_DEST_ACC = 1'b0;
    localparam logic BLMX_DEST_REG = 1'b1;

    // Operation codes as issued by the decode sequencer
    typedef enum logic [2:0] {
        BLMX_OP_NOP      = 3'h0,
        BLMX_OP_SET_BIT  = 3'h1,
        BLMX_OP_AND_IMM  = 3'h2,
        BLMX_OP_AND_REG  = 3'h3,
        BLMX_OP_SKIP_ONE = 3'h4,
        BLMX_OP_SKIP_ZER = 3'h5,
        BLMX_OP_COPY_REG = 3'h6
    } blmx_op_t;

    typedef struct packed {
        blmx_op_t   op;
        logic [6:0] addr;
        logic [2:0] bit_sel;
        logic       dest;
        logic [7:0] imm;
    } blmx_instr_t;

    typedef enum logic [2:0] {
        BLMX_ST_IDLE  = 3'b001,
        BLMX_ST_EXEC  = 3'b010,
        BLMX_ST_FLUSH = 3'b100
    } blmx_state_t;

endpackage

// ---- rtl/blmx_regfile.sv ----
`timescale 1ns/10ps
`default_nettype none
module blmx_regfile #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int DEPTH  = 128
) (
    // Clock
    input  wire logic              core_clk,
    // Read port, data registered
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- test/blmx_exec_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module blmx_exec_asserts
    import blmx_pkg::*;
(
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // Issue
    input wire logic                  instr_valid,
    input wire blmx_pkg::blmx_instr_t instr,
    // State
    input wire logic [7:0]            acc_out,
    input wire logic                  zero_flag,
    input wire logic                  busy,
    input wire logic                  skip_taken,
    input wire logic                  done
);
    blmx_instr_t cur_r;
    wire logic   is_dacc = cur_r.dest == BLMX_DEST_ACC;
    always_ff @(posedge core_clk) begin
        if (instr_valid && !busy) cur_r <= instr;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_issue_to_done: assert property (instr_valid && !busy |=> busy ##1 done)
        else $error("done not two cycles after issue");
    a_and_imm_result: assert property (done && cur_r.op == BLMX_OP_AND_IMM
        |-> acc_out == ($past(acc_out, 2) & cur_r.imm) && zero_flag == (acc_out == 8'h00))
        else $error("and immediate result wrong");
    a_no_flag_ops: assert property (done && cur_r.op inside {BLMX_OP_NOP, BLMX_OP_SET_BIT,
        BLMX_OP_SKIP_ONE, BLMX_OP_SKIP_ZER} |-> $stable(acc_out) && $stable(zero_flag))
        else $error("accumulator or zero changed");
    a_acc_kept: assert property (done && !is_dacc && cur_r.op inside {BLMX_OP_AND_REG,
        BLMX_OP_COPY_REG} |-> $stable(acc_out)) else $error("accumulator written");
    a_and_subset: assert property (done && is_dacc && cur_r.op == BLMX_OP_AND_REG
        |-> (acc_out & ~$past(acc_out, 2)) == 8'h00) else $error("and set new bits");
    a_zero_from_acc: assert property (done && is_dacc && cur_r.op inside {BLMX_OP_AND_REG,
        BLMX_OP_COPY_REG} |-> zero_flag == (acc_out == 8'h00)) else $error("zero flag wrong");
    a_skip_flush: assert property (skip_taken |-> busy ##1 (!busy && !skip_taken))
        else $error("flush slot wrong");
    a_skip_cause: assert property (skip_taken |-> done && cur_r.op inside
        {BLMX_OP_SKIP_ONE, BLMX_OP_SKIP_ZER}) else $error("skip from wrong op");
    c_skip: cover property (skip_taken);
    c_copy_self: cover property (done && !is_dacc && cur_r.op == BLMX_OP_COPY_REG);
    c_and_imm: cover property (done && cur_r.op == BLMX_OP_AND_IMM);
endmodule
bind blmx_exec blmx_exec_asserts u_chk (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .acc_out(acc_out), .zero_flag(zero_flag), .busy(busy),
    .skip_taken(skip_taken), .done(done));
`default_nettype wire

// ---- test/blmx_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module blmx_seq_model
    import blmx_pkg::*;
(
    // Clock and completion
    input wire logic              core_clk,
    input wire logic              done,
    input wire logic              skip_taken,
    // Issue
    output logic                  instr_valid,
    output blmx_pkg::blmx_instr_t instr
);
    initial begin
        instr_valid = 1'b0;
        instr = '0;
    end
    // Called at a falling edge; returns at one
    task automatic issue(input blmx_instr_t i, output logic sk);
        int n;
        n = 0;
        instr_valid = 1'b1;
        instr = i;
        @(negedge core_clk);
        instr_valid = 1'b0;
        instr = blmx_instr_t'(~i);
        while (done !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        sk = skip_taken;
        if (sk === 1'b1) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ---- test/bit_logic_move_instr_exec_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module bit_logic_move_instr_exec_bench;
    import blmx_pkg::*;
    typedef struct packed {blmx_instr_t i; logic [7:0] acc; logic z; logic sk;} blmx_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid, zero_flag, busy, skip_taken, done, sk;
    blmx_instr_t instr;
    logic [7:0] acc_out;
    int fail_count = 0;
    int n_tests = 0;
    // Register file is unknown at reset; zero cells via AND with reset accumulator
    blmx_row_t rows [13] = '{
        '{'{BLMX_OP_AND_REG, 7'h05, 3'h0, 1'b1, 8'h00}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_AND_REG, 7'h09, 3'h0, 1'b1, 8'h00}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_SET_BIT, 7'h05, 3'h7, 1'b0, 8'h00}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_COPY_REG, 7'h05, 3'h0, 1'b0, 8'h00}, 8'h80, 1'b0, 1'b0},
        '{'{BLMX_OP_COPY_REG, 7'h09, 3'h0, 1'b1, 8'h00}, 8'h80, 1'b1, 1'b0},
        '{'{BLMX_OP_AND_IMM, 7'h00, 3'h0, 1'b0, 8'hc0}, 8'h80, 1'b0, 1'b0},
        '{'{BLMX_OP_AND_IMM, 7'h00, 3'h0, 1'b0, 8'h7f}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_COPY_REG, 7'h05, 3'h0, 1'b0, 8'h00}, 8'h80, 1'b0, 1'b0},
        '{'{BLMX_OP_AND_REG, 7'h09, 3'h0, 1'b0, 8'h00}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_NOP, 7'h05, 3'h0, 1'b1, 8'hff}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_SKIP_ONE, 7'h05, 3'h7, 1'b0, 8'h00}, 8'h00, 1'b1, 1'b1},
        '{'{BLMX_OP_SKIP_ZER, 7'h05, 3'h7, 1'b0, 8'h00}, 8'h00, 1'b1, 1'b0},
        '{'{BLMX_OP_SKIP_ZER, 7'h05, 3'h3, 1'b0, 8'h00}, 8'h00, 1'b1, 1'b1}};
    always #20 core_clk = ~core_clk;
    blmx_seq_model seq (.core_clk(core_clk), .done(done), .skip_taken(skip_taken),
        .instr_valid(instr_valid), .instr(instr));
    blmx_exec dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .acc_out(acc_out), .zero_flag(zero_flag), .busy(busy), .skip_taken(skip_taken),
        .done(done));
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        `CHK("busy", 1'b0, busy)
        foreach (rows[k]) begin
            seq.issue(rows[k].i, sk);
            `CHK("skip", rows[k].sk, sk)
            `CHK("acc", rows[k].acc, acc_out)
            `CHK("zero", rows[k].z, zero_flag)
        end
        seq.issue(rows[7].i, sk);
        rst = 1'b1;
        @(negedge core_clk);
        `CHK("acc", 8'h00, acc_out)
        `CHK("zero", 1'b0, zero_flag)
        `CHK("busy", 1'b0, busy)
        rst = 1'b0;
        @(negedge core_clk);
        // File register survives reset; copy bit-set cell to accumulator
        seq.issue(rows[3].i, sk);
        `CHK("acc", 8'h80, acc_out)
        `CHK("zero", 1'b0, zero_flag)
        conclude;
    end
    // Whole run is about 40 cycles; this leaves ample margin
    initial begin
        #50000;
        fail_count++;
        conclude;
    end
endmodule
`default_nettype wire
